/* File: vtm_pkg.sv */
// Functional notes
// - Trim register is a signed 16-bit offset added to the commanded voltage.
// - Trim is read with the exponent currently selected by the output mode.
// - Nonvolatile trim keeps eight bits at a fixed exponent of minus twelve.
// - Saved trim saturates to +127..-128 whatever the active exponent.
// - Valid command/margin plus trim range depends on the loop scale setting.
// - Sum above DAC maximum but below ceiling clamps at DAC max, no warning.
// - Out-of-range trim write is invalid data: flag status and notify host.
// - Trim pushing past ceiling or floor moves reference there; it warns only while converting.
// - The ceiling register is an absolute limit on the output target; here a floor set above it still wins when the sum is not over it.
// - Ceiling holds a 16-bit unsigned absolute value in the mode exponent.
// - While converting, an over-ceiling target goes to ceiling at slew rate.
// - Warning sets none-of-above, word vout bit and the max/min warning bit.
// - Warning notifies the host through the warning alert.
// - Writing the ceiling below the target gives the same warning response.
// - Upper margin holds a 16-bit unsigned target in the mode exponent.
// - With margin high selected the target is upper margin plus trim.
// - Entering or leaving margin ramps at the programmed transition rate.
// - Margin plus trim is checked against the ceiling and the same limits.
// - Out-of-range upper margin write is invalid data, flagged and notified.
// - Turn-on and turn-off ramps ignore the programmed transition rate.
// - Output exponent is two's complement, limited to -4 through -12.
package vtm_pkg;
    // ==========================================================
    // Command codes and register slots
    localparam logic [7:0] CODE_TRIM = 8'h22;
    localparam logic [7:0] CODE_CEIL = 8'h24;
    localparam logic [7:0] CODE_MARGH = 8'h25;
    localparam logic [1:0] SLOT_TRIM = 2'h0;
    localparam logic [1:0] SLOT_CEIL = 2'h1;
    localparam logic [1:0] SLOT_MARGH = 2'h2;
    localparam int SLOT_COUNT = 3;
    // Values after reset
    localparam logic [15:0] RST_TRIM = 16'h0000;
    localparam logic [15:0] RST_CEIL = 16'hFFFF;
    localparam logic [15:0] RST_MARGH = 16'h0000;
    // ==========================================================
    // Exponent range and internal fixed exponent
    localparam int EXP_MIN = -12;
    localparam int EXP_MAX = -4;
    localparam int LSB_PER_VOLT = 4096;
    // DAC limits per loop scale, in millivolts
    localparam int RANGE_MV_S1 = 700;
    localparam int RANGE_MV_S2 = 1400;
    localparam int RANGE_MV_S4 = 2800;
    localparam int RANGE_MV_S8 = 6000;
    localparam logic [1:0] SCALE_1 = 2'h0;
    localparam logic [1:0] SCALE_2 = 2'h1;
    localparam logic [1:0] SCALE_4 = 2'h2;
    localparam logic [1:0] SCALE_8 = 2'h3;
    // Saved trim limits
    localparam int NVM_MAX = 127;
    localparam int NVM_MIN = -128;
    // ==========================================================
    // Slew tick: one per microsecond
    localparam int CLOCK_HZ = 25000000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (CLOCK_HZ / 1000000) * TICK_NS / 1000;
    localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
    // ==========================================================
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } vtm_req_t;
    typedef struct packed {
        logic valid;
        logic unsupported;
        logic [15:0] data;
    } vtm_resp_t;
    typedef struct packed {
        logic noneOfAbove;
        logic wordVout;
        logic maxMinWarn;
        logic invalidData;
    } vtm_status_t;
endpackage

/* File: vtm_reg_mem.sv */
`timescale 1ns/10ps
// Three-word register store with registered read port
module vtm_reg_mem (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [1:0] wrSlot,
    input wire logic [15:0] wrData,
    input wire logic [1:0] rdSlot,
    output logic [15:0] rdData,
    output logic [15:0] trimWord,
    output logic [15:0] ceilWord,
    output logic [15:0] marghWord
);
    logic [15:0] store [vtm_pkg::SLOT_COUNT];
    localparam logic [15:0] RST_VALS [vtm_pkg::SLOT_COUNT] = '{
        vtm_pkg::RST_TRIM, vtm_pkg::RST_CEIL, vtm_pkg::RST_MARGH};

    // ==========================================================
    // Storage words, one flop group per slot
    genvar g;
    generate
        for (g = 0; g < vtm_pkg::SLOT_COUNT; g++) begin : gSlot
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    store[g] <= RST_VALS[g];
                end else if (wrEn && wrSlot == 2'(g)) begin
                    store[g] <= wrData;
                end
            end
        end
    endgenerate

    // Read data registered to keep the host path timing clean
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdData <= 16'h0000;
        end else if (rdSlot < 2'(vtm_pkg::SLOT_COUNT)) begin
            rdData <= store[rdSlot];
        end else begin
            rdData <= 16'h0000;
        end
    end

    assign trimWord = store[vtm_pkg::SLOT_TRIM];
    assign ceilWord = store[vtm_pkg::SLOT_CEIL];
    assign marghWord = store[vtm_pkg::SLOT_MARGH];
endmodule

/* File: vtm_limit_regs.sv */
`timescale 1ns/10ps
// Trim, ceiling and upper margin command logic with target clamping
module vtm_limit_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire vtm_pkg::vtm_req_t hostReq,
    output vtm_pkg::vtm_resp_t hostResp,
    input wire logic [15:0] voutCommand,
    input wire logic [15:0] voutFloor,
    input wire logic [4:0] modeExp,
    input wire logic [1:0] scaleSel,
    input wire logic marginHighSel,
    input wire logic convEnable,
    input wire logic onOffRamp,
    input wire logic [15:0] slewStep,
    input wire logic statusClear,
    input wire logic nvmRestore,
    input wire logic [7:0] nvmRestoreByte,
    output logic [15:0] dacRef,
    output vtm_pkg::vtm_status_t status,
    output logic warnAlert,
    output logic invalidAlert,
    output logic [7:0] nvmTrimByte
);
    // ==========================================================
    // Helper functions
    // Shift that moves a mode value to the fixed -12 exponent
    function automatic logic [3:0] exp_shift(input logic [4:0] e);
        logic signed [5:0] se;
        se = 6'(signed'(e));
        if (se < 6'(vtm_pkg::EXP_MIN)) begin
            exp_shift = 4'h0;
        end else if (se > 6'(vtm_pkg::EXP_MAX)) begin
            exp_shift = 4'(vtm_pkg::EXP_MAX - vtm_pkg::EXP_MIN);
        end else begin
            exp_shift = 4'(se - 6'(vtm_pkg::EXP_MIN));
        end
    endfunction

    function automatic logic signed [31:0] align_u(input logic [15:0] v,
            input logic [3:0] sh);
        align_u = signed'({16'h0000, v}) <<< sh;
    endfunction

    function automatic logic signed [31:0] align_s(input logic [15:0] v,
            input logic [3:0] sh);
        align_s = 32'(signed'(v)) <<< sh;
    endfunction

    function automatic logic signed [31:0] dac_max(input logic [1:0] s);
        unique case (s)
            vtm_pkg::SCALE_1: dac_max = 32'(vtm_pkg::RANGE_MV_S1
                * vtm_pkg::LSB_PER_VOLT / 1000);
            vtm_pkg::SCALE_2: dac_max = 32'(vtm_pkg::RANGE_MV_S2
                * vtm_pkg::LSB_PER_VOLT / 1000);
            vtm_pkg::SCALE_4: dac_max = 32'(vtm_pkg::RANGE_MV_S4
                * vtm_pkg::LSB_PER_VOLT / 1000);
            vtm_pkg::SCALE_8: dac_max = 32'(vtm_pkg::RANGE_MV_S8
                * vtm_pkg::LSB_PER_VOLT / 1000);
        endcase
    endfunction

    // ==========================================================
    // Register store
    logic [15:0] trimWord;
    logic [15:0] ceilWord;
    logic [15:0] marghWord;
    logic [15:0] memRdData;
    logic memWrEn;
    logic [1:0] memWrSlot;
    logic [15:0] memWrData;
    logic [1:0] reqSlot;
    logic reqKnown;

    vtm_reg_mem uMem (
        .clock(clock),
        .rst_n(rst_n),
        .wrEn(memWrEn),
        .wrSlot(memWrSlot),
        .wrData(memWrData),
        .rdSlot(reqSlot),
        .rdData(memRdData),
        .trimWord(trimWord),
        .ceilWord(ceilWord),
        .marghWord(marghWord)
    );

    // ==========================================================
    // Aligned operands, all at the -12 exponent
    logic [3:0] shamt;
    logic signed [31:0] trimA;
    logic signed [31:0] baseA;
    logic signed [31:0] ceilA;
    logic signed [31:0] floorA;
    logic signed [31:0] dacMaxA;
    logic signed [31:0] sumA;
    logic signed [31:0] wrSumA;
    logic wrInRange;

    assign shamt = exp_shift(modeExp);
    assign trimA = align_s(trimWord, shamt);
    assign ceilA = align_u(ceilWord, shamt);
    assign floorA = align_u(voutFloor, shamt);
    assign dacMaxA = dac_max(scaleSel);
    // Margin high replaces the command as the base
    assign baseA = marginHighSel ? align_u(marghWord, shamt)
        : align_u(voutCommand, shamt);
    assign sumA = baseA + trimA;

    // Decode of the addressed slot
    always_comb begin
        reqKnown = 1'b1;
        reqSlot = vtm_pkg::SLOT_TRIM;
        unique case (hostReq.code)
            vtm_pkg::CODE_TRIM: reqSlot = vtm_pkg::SLOT_TRIM;
            vtm_pkg::CODE_CEIL: reqSlot = vtm_pkg::SLOT_CEIL;
            vtm_pkg::CODE_MARGH: reqSlot = vtm_pkg::SLOT_MARGH;
            default: reqKnown = 1'b0;
        endcase
    end

    // Sum a write would produce; the ceiling is not a range check
    always_comb begin
        wrSumA = sumA;
        if (reqSlot == vtm_pkg::SLOT_TRIM) begin
            wrSumA = align_u(voutCommand, shamt)
                + align_s(hostReq.data, shamt);
        end else if (reqSlot == vtm_pkg::SLOT_MARGH) begin
            wrSumA = align_u(hostReq.data, shamt) + trimA;
        end
    end
    assign wrInRange = (reqSlot == vtm_pkg::SLOT_CEIL)
        || (wrSumA >= 0 && wrSumA <= dacMaxA);

    // ==========================================================
    // Write path; invalid data is refused and never stored
    logic hostWrite;
    logic badWrite;
    logic signed [31:0] restoreA;
    assign hostWrite = hostReq.valid && hostReq.write && reqKnown;
    assign badWrite = hostWrite && !wrInRange;
    // Restored byte is at -12; shift back to the active exponent
    assign restoreA = 32'(signed'(nvmRestoreByte)) >>> shamt;

    always_comb begin
        memWrEn = 1'b0;
        memWrSlot = reqSlot;
        memWrData = hostReq.data;
        if (hostWrite && wrInRange) begin
            memWrEn = 1'b1;
        end else if (nvmRestore) begin
            memWrEn = 1'b1;
            memWrSlot = vtm_pkg::SLOT_TRIM;
            memWrData = restoreA[15:0];
        end
    end

    // Read answer one cycle after the request
    logic respValid;
    logic respUnsup;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            respValid <= 1'b0;
            respUnsup <= 1'b0;
        end else begin
            respValid <= hostReq.valid && !hostReq.write;
            respUnsup <= hostReq.valid && !reqKnown;
        end
    end
    assign hostResp = '{valid: respValid, unsupported: respUnsup,
        data: memRdData};

    // ==========================================================
    // Target clamping: ceiling first, then floor, then DAC range
    logic signed [31:0] next_target;
    logic overLimit;
    always_comb begin
        next_target = sumA;
        overLimit = 1'b0;
        if (sumA > ceilA) begin
            next_target = ceilA;
            overLimit = 1'b1;
        end else if (sumA < floorA) begin
            next_target = floorA;
            overLimit = 1'b1;
        end
        // Quiet clamp: DAC limit alone raises no warning
        if (next_target > dacMaxA) begin
            next_target = dacMaxA;
        end
        if (next_target < 0) begin
            next_target = 32'sh0;
        end
    end

    logic [15:0] target;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            target <= 16'h0000;
        end else begin
            target <= next_target[15:0];
        end
    end

    // ==========================================================
    // Warning detect: new entry into the limit, or any known-code write while held
    logic warnCond;
    logic warnPrev;
    logic warnEvent;
    assign warnCond = convEnable && overLimit;
    assign warnEvent = warnCond && (!warnPrev || hostWrite);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            warnPrev <= 1'b0;
        end else begin
            warnPrev <= warnCond;
        end
    end

    // Sticky status bits; a new event wins over a clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            if (warnEvent) begin
                status.noneOfAbove <= 1'b1;
                status.wordVout <= 1'b1;
                status.maxMinWarn <= 1'b1;
            end else if (statusClear) begin
                status.noneOfAbove <= 1'b0;
                status.wordVout <= 1'b0;
                status.maxMinWarn <= 1'b0;
            end
            if (badWrite) begin
                status.invalidData <= 1'b1;
            end else if (statusClear) begin
                status.invalidData <= 1'b0;
            end
        end
    end

    // Host notification pulses
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            warnAlert <= 1'b0;
            invalidAlert <= 1'b0;
        end else begin
            warnAlert <= warnEvent;
            invalidAlert <= badWrite;
        end
    end

    // ==========================================================
    // Saved trim byte: -12 exponent, saturated to one signed byte
    logic signed [31:0] trimFixed;
    assign trimFixed = trimA;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            nvmTrimByte <= 8'h00;
        end else if (trimFixed > vtm_pkg::NVM_MAX) begin
            nvmTrimByte <= 8'(vtm_pkg::NVM_MAX);
        end else if (trimFixed < vtm_pkg::NVM_MIN) begin
            nvmTrimByte <= 8'(vtm_pkg::NVM_MIN);
        end else begin
            nvmTrimByte <= trimFixed[7:0];
        end
    end

    // ==========================================================
    // Microsecond tick for the slew ramp
    logic [4:0] tickCount;
    logic tick;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tickCount <= 5'h00;
            tick <= 1'b0;
        end else begin
            tick <= (tickCount == vtm_pkg::TICK_LAST);
            tickCount <= (tickCount == vtm_pkg::TICK_LAST) ? 5'h00
                : tickCount + 5'h01;
        end
    end

    // Reference ramp; turn-on and turn-off moves skip the slew limit
    logic [16:0] upSum;
    logic [16:0] downDiff;
    assign upSum = {1'b0, dacRef} + {1'b0, slewStep};
    assign downDiff = {1'b0, dacRef} - {1'b0, slewStep};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dacRef <= 16'h0000;
        end else if (onOffRamp) begin
            dacRef <= target;
        end else if (tick && dacRef < target) begin
            dacRef <= (upSum > {1'b0, target}) ? target
                : upSum[15:0];
        end else if (tick && dacRef > target) begin
            dacRef <= (downDiff[16] || downDiff < {1'b0, target})
                ? target : downDiff[15:0];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_warn_seen;
        warnEvent;
    endsequence
    sequence s_warn_shown;
        warnAlert && status.maxMinWarn && status.wordVout;
    endsequence

    a_warn_status_set: assert property (s_warn_seen |=> s_warn_shown)
        else $error("warning did not set status and alert");
    a_warn_alert_cause: assert property (warnAlert |->
        $past(convEnable) && $past(overLimit))
        else $error("warning alert without a limit violation");
    a_bad_write_drop: assert property (badWrite && !nvmRestore |=>
        $stable(trimWord) && $stable(marghWord) && invalidAlert)
        else $error("invalid write stored or not flagged");
    a_ceiling_hold: assert property (!onOffRamp ##1 !onOffRamp |->
        $past(ceilA) < 0 || 32'(target) <= $past(ceilA)
        || 32'(target) <= $past(floorA))
        else $error("target above ceiling");
    // Scale may change under the clamp, so compare with last cycle's limit
    a_dac_quiet_clamp: assert property (sumA > dacMaxA
        && sumA <= ceilA && sumA >= floorA |-> !overLimit
        ##1 32'(target) == $past(dacMaxA))
        else $error("DAC clamp wrong or warned");
    a_nvm_saturate: assert property (trimFixed > vtm_pkg::NVM_MAX |=>
        nvmTrimByte == 8'(vtm_pkg::NVM_MAX))
        else $error("saved trim not saturated");
    a_bypass_jump: assert property (onOffRamp |=>
        dacRef == $past(target))
        else $error("turn on or off ramp was slew limited");
    a_slew_bound: assert property (!onOffRamp && !tick |=>
        $stable(dacRef))
        else $error("reference moved between slew ticks");
    // At the native exponent the base is the raw margin word plus raw trim
    a_margin_base: assert property (marginHighSel
        && shamt == 4'h0 |-> sumA == 32'(marghWord)
        + 32'(signed'(trimWord)))
        else $error("margin high not used as base");
endmodule

/* File: vtm_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Host side of the word command bus
module vtm_host_model (
    input wire logic clock,
    output vtm_pkg::vtm_req_t hostReq,
    input wire vtm_pkg::vtm_resp_t hostResp
);
    // Bus starts idle
    initial begin
        hostReq = '0;
    end
    // One word held to the taking edge; released lines go inverted
    task automatic xfer(input logic wr, input logic [7:0] code,
            input logic [15:0] data, input int gap);
        repeat (gap + 1) @(posedge clock);
        hostReq <= '{1'b1, wr, code, data};
        @(posedge clock);
        hostReq <= '{1'b0, ~wr, ~code, ~data};
    endtask
    // Word write, no answer expected
    task automatic write_word(input logic [7:0] code,
            input logic [15:0] data);
        xfer(1'b1, code, data, 0);
    endtask
    // Word read; answer is in the cycle after the taking edge
    task automatic read_word(input logic [7:0] code, input int gap,
            output logic ok, output logic unsup, output logic [15:0] d);
        xfer(1'b0, code, 16'h0000, gap);
        #1;
        ok = hostResp.valid;
        unsup = hostResp.unsupported;
        d = hostResp.data;
    endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
// ==========================================================
// Bench for the trim, ceiling and upper margin logic
module tb_top;
    localparam logic [7:0] CT = vtm_pkg::CODE_TRIM;
    localparam logic [7:0] CC = vtm_pkg::CODE_CEIL;
    localparam logic [7:0] CM = vtm_pkg::CODE_MARGH;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    vtm_pkg::vtm_req_t hostReq;
    vtm_pkg::vtm_resp_t hostResp;
    logic [15:0] voutCommand = 16'h03E8;
    logic [15:0] voutFloor = 16'h0000;
    logic [4:0] modeExp = 5'h14;
    logic [1:0] scaleSel = vtm_pkg::SCALE_8;
    logic marginHighSel = 1'b0;
    logic convEnable = 1'b1;
    logic onOffRamp = 1'b1;
    logic [15:0] slewStep = 16'h000A;
    logic statusClear = 1'b0;
    logic nvmRestore = 1'b0;
    logic [7:0] nvmRestoreByte = 8'h10;
    logic [15:0] dacRef;
    vtm_pkg::vtm_status_t status;
    logic warnAlert;
    logic invalidAlert;
    logic [7:0] nvmTrimByte;
    int fails = 0;
    int num_checks = 0;
    logic w;
    logic inv;

    // 25 MHz clock
    always #20 clock = ~clock;

    vtm_limit_regs vtm_limit_regs_inst (
        .clock(clock), .rst_n(rst_n), .hostReq(hostReq),
        .hostResp(hostResp), .voutCommand(voutCommand),
        .voutFloor(voutFloor), .modeExp(modeExp), .scaleSel(scaleSel),
        .marginHighSel(marginHighSel), .convEnable(convEnable),
        .onOffRamp(onOffRamp), .slewStep(slewStep),
        .statusClear(statusClear), .nvmRestore(nvmRestore),
        .nvmRestoreByte(nvmRestoreByte), .dacRef(dacRef),
        .status(status), .warnAlert(warnAlert),
        .invalidAlert(invalidAlert), .nvmTrimByte(nvmTrimByte)
    );
    vtm_host_model vtm_host_model_inst (
        .clock(clock), .hostReq(hostReq), .hostResp(hostResp)
    );

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] code, input logic [15:0] d);
        vtm_host_model_inst.write_word(code, d);
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic ok;
        logic un;
        logic [15:0] d;
        vtm_host_model_inst.read_word(code, 0, ok, un, d);
        check({ok, un, d}, {2'b10, exp});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Alerts are single-cycle pulses, so every cycle is looked at
    task automatic catch_alerts(input int n);
        w = 1'b0;
        inv = 1'b0;
        repeat (n) begin
            #1;
            w = w | warnAlert;
            inv = inv | invalidAlert;
            @(posedge clock);
        end
    endtask
    task automatic clear_status();
        @(posedge clock);
        statusClear <= 1'b1;
        @(posedge clock);
        statusClear <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_values();
        logic ok;
        logic un;
        logic [15:0] d;
        rd(CT, vtm_pkg::RST_TRIM);
        rd(CC, vtm_pkg::RST_CEIL);
        rd(CM, vtm_pkg::RST_MARGH);
        vtm_host_model_inst.read_word(8'h23, 3, ok, un, d);
        // Unknown code still answers a read, flagged as unsupported
        check({ok, un, d}, {2'b11, 16'h0000});
    endtask
    task automatic t_trim_offset();
        wr(CT, 16'h00C8);
        rd(CT, 16'h00C8);
        settle(3);
        check(dacRef, 16'h04B0);
        check(nvmTrimByte, 8'h7F);
        wr(CT, 16'hFED4);
        settle(4);
        check(dacRef, 16'h02BC);
        check(nvmTrimByte, 8'h80);
        wr(CT, 16'hFFFB);
        settle(4);
        check(nvmTrimByte, 8'hFB);
        @(posedge clock);
        nvmRestore <= 1'b1;
        @(posedge clock);
        nvmRestore <= 1'b0;
        rd(CT, 16'h0010);
        @(posedge clock);
        // Exponent -8: command 100 and trim 16 align to -12 LSBs
        modeExp <= 5'h18;
        voutCommand <= 16'h0064;
        settle(4);
        check(dacRef, 16'h0740);
        @(posedge clock);
        // Exponent -2 is outside the range and saturates to -4
        modeExp <= 5'h1E;
        voutCommand <= 16'h0001;
        settle(4);
        check(dacRef, 16'h1100);
        @(posedge clock);
        modeExp <= 5'h14;
        voutCommand <= 16'h03E8;
        wr(CT, 16'h0000);
        settle(4);
    endtask
    task automatic t_range_limits();
        @(posedge clock);
        voutCommand <= 16'h0AF0;
        wr(CT, 16'h0064);
        settle(3);
        @(posedge clock);
        scaleSel <= vtm_pkg::SCALE_1;
        clear_status();
        settle(4);
        check(dacRef, 16'h0B33);
        check(status.maxMinWarn, 1'b0);
        wr(CT, 16'h0078);
        catch_alerts(3);
        check({inv, status.invalidData}, 2'b11);
        rd(CT, 16'h0064);
        // A sum below zero is refused as well
        wr(CT, 16'hF448);
        catch_alerts(3);
        check(inv, 1'b1);
        // Middle scales: one LSB over the range is refused; the edge is kept at scale 2
        scaleSel <= vtm_pkg::SCALE_2;
        wr(CT, 16'h0B77);
        catch_alerts(3);
        check(inv, 1'b1);
        wr(CT, 16'h0B76);
        catch_alerts(3);
        check({inv, dacRef}, {1'b0, 16'h1666});
        scaleSel <= vtm_pkg::SCALE_4;
        wr(CT, 16'h21DD);
        catch_alerts(3);
        check(inv, 1'b1);
        scaleSel <= vtm_pkg::SCALE_8;
        voutCommand <= 16'h03E8;
        wr(CT, 16'h0000);
        clear_status();
        settle(4);
    endtask
    task automatic t_ceiling();
        wr(CC, 16'h0320);
        catch_alerts(4);
        check(w, 1'b1);
        settle(2);
        check(dacRef, 16'h0320);
        check({status.noneOfAbove, status.wordVout, status.maxMinWarn},
            3'b111);
        rd(CC, 16'h0320);
        clear_status();
        wr(CT, 16'h0032);
        catch_alerts(4);
        check({w, status.maxMinWarn}, 2'b11);
        settle(2);
        check(dacRef, 16'h0320);
        wr(CC, 16'hFFFF);
        voutFloor <= 16'h04B0;
        wr(CT, 16'h0000);
        catch_alerts(4);
        settle(2);
        check({w, dacRef}, {1'b1, 16'h04B0});
        @(posedge clock);
        voutFloor <= 16'h0000;
        clear_status();
        settle(3);
        check(status, 4'h0);
        // No warning while conversion is off, but the ceiling still holds
        @(posedge clock);
        convEnable <= 1'b0;
        wr(CC, 16'h0320);
        catch_alerts(4);
        settle(2);
        check({w, dacRef}, {1'b0, 16'h0320});
        wr(CC, 16'hFFFF);
        convEnable <= 1'b1;
        settle(4);
    endtask
    task automatic t_margin_high();
        wr(CM, 16'h04B0);
        rd(CM, 16'h04B0);
        wr(CT, 16'h0064);
        settle(4);
        @(posedge clock);
        onOffRamp <= 1'b0;
        marginHighSel <= 1'b1;
        // Ramp of 10 LSBs per 25-cycle tick, so only one or two steps
        settle(30);
        check(dacRef >= 16'h0456 && dacRef <= 16'h0460, 1'b1);
        settle(500);
        check(dacRef, 16'h0514);
        wr(CM, 16'h6000);
        catch_alerts(3);
        check(inv, 1'b1);
        rd(CM, 16'h04B0);
        wr(CC, 16'h04E2);
        catch_alerts(4);
        check(w, 1'b1);
        settle(3);
        check(dacRef > 16'h04E2, 1'b1);
        settle(160);
        check(dacRef, 16'h04E2);
        @(posedge clock);
        onOffRamp <= 1'b1;
        marginHighSel <= 1'b0;
        settle(3);
        check(dacRef, 16'h044C);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check({dacRef, status, warnAlert, invalidAlert}, 22'h0);
        t_reset_values();
        t_trim_offset();
        t_range_limits();
        t_ceiling();
        t_margin_high();
        results();
    end
    // Watchdog well beyond the roughly 900 cycles the tests take
    initial begin
        repeat (6000) @(posedge clock);
        fails++;
        results();
    end
endmodule
